// ### include/fbgp_defines.svh
`ifndef FBGP_DEFINES_SVH
`define FBGP_DEFINES_SVH

// Register byte addresses on the Avalon-MM slave.
`define FBGP_ADDR_PIN_STATE   8'h00
`define FBGP_ADDR_DIRECTION   8'h04
`define FBGP_ADDR_LATCH       8'h08
`define FBGP_ADDR_ANALOG      8'h0C
`define FBGP_ADDR_PULLUP      8'h10
`define FBGP_ADDR_OPEN_DRAIN  8'h14
`define FBGP_ADDR_SLEW        8'h18
`define FBGP_ADDR_THRESHOLD   8'h1C
`define FBGP_ADDR_MCLR_CTRL   8'h20

// Field positions and widths.
`define FBGP_NUM_PINS         4
`define FBGP_PIN3_BIT         3
`define FBGP_OUT_PINS         3

// Reset values, each sized to its register: one, three or four bits.
`define FBGP_RST_DIRECTION    4'hF
`define FBGP_RST_LATCH        3'h7
`define FBGP_RST_ANALOG       3'h7
`define FBGP_RST_PULLUP       4'hF
`define FBGP_RST_OPEN_DRAIN   3'h0
`define FBGP_RST_SLEW         3'h7
`define FBGP_RST_THRESHOLD    4'hF
`define FBGP_RST_MCLR         1'h0

// Unmapped reads return this word.
`define FBGP_UNMAPPED_DATA    32'h0000_0000

`endif

// ### include/fbgp_pkg.sv
package fbgp_pkg;
    // Slave handshake phase.
    typedef enum logic [0:0] {
        FBGP_IDLE,
        FBGP_DONE
    } fbgp_bus_state_type;

    typedef logic [3:0] fbgp_pins_type;
    typedef logic [2:0] fbgp_out_type;
endpackage

// ### hdl/fbgp_port.sv
// Functional notes
// R1: Direction one inputs, zero drives latch.
// R2: Data read shows pins, write hits latch.
// R3: Port write samples pins, then stores latch.
// R4: Analog select forces digital reads to zero.
// R5: Software keeps analog pins set as inputs.
// R6: Pin 3 direction reads one, never drives.
// R7: Open-drain bit makes pin sink only.
// R8: Slew bit limits drive rate per pin.
// R9: Threshold bit picks Schmitt or TTL input.
// R10: Change thresholds only with peripherals disabled.
// R11: Analog select never blocks digital output.
// R12: Analog select resets to one, software clears.
// R13: Pull-up follows its bit, off when output.
// R14: Master clear forces pin 3 pull-up on.
// R15: After reset, outputs come from port latch.
// R16: Digital output keeps pin while analog set.
// R17: Data register low nibble pins, upper zero.
// R18: Reset values for all configuration registers.
`timescale 1ns/10ps
`include "fbgp_defines.svh"

module fbgp_port #(
    parameter int NUM_PINS = `FBGP_NUM_PINS
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_arst_n,
    input  wire logic [7:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic      [31:0]             o_avs_readdata,
    output logic                         o_avs_waitrequest,
    input  wire fbgp_pkg::fbgp_pins_type i_pin_in,
    input  wire fbgp_pkg::fbgp_pins_type i_pin_schmitt,
    output fbgp_pkg::fbgp_out_type       o_pin_out,
    output fbgp_pkg::fbgp_out_type       o_pin_oe_n,
    output fbgp_pkg::fbgp_out_type       o_slew_limit,
    output fbgp_pkg::fbgp_pins_type      o_pullup_on,
    output fbgp_pkg::fbgp_pins_type      o_schmitt_sel,
    output fbgp_pkg::fbgp_out_type       o_analog_sel
);
    import fbgp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    fbgp_bus_state_type bus_state_q;     // Handshake phase of the slave.
    logic [31:0]        rdata_q;         // Registered read data.
    logic [3:0]         dir_q;           // Direction; bit 3 held at one.
    fbgp_out_type       latch_q;         // Output latch for pins 2..0.
    fbgp_out_type       analog_q;        // Analog select, pins 2..0.
    fbgp_pins_type      pullup_q;        // Stored pull-up bits.
    fbgp_out_type       odrain_q;        // Open-drain enables.
    fbgp_out_type       slew_q;          // Slew limit enables.
    fbgp_pins_type      thresh_q;        // One selects Schmitt input.
    logic               mclr_q;          // Master clear pin enable.
    fbgp_pins_type      ttl_meta_q;      // First synchroniser stage, TTL path.
    fbgp_pins_type      ttl_sync_q;      // Second synchroniser stage, TTL path.
    fbgp_pins_type      st_meta_q;       // First synchroniser stage, Schmitt path.
    fbgp_pins_type      st_sync_q;       // Second synchroniser stage, Schmitt path.
    fbgp_pins_type      pin_state;       // Digital pin state as software sees it.
    logic               wr_hit;          // Write accepted this cycle.
    logic               rd_hit;          // Read accepted this cycle.
    fbgp_out_type       pin_out_d;       // Next pin drive levels.
    fbgp_out_type       oe_n_d;          // Next output enables, low drives.
    fbgp_pins_type      pullup_d;        // Next pull-up controls.

    // Byte lane zero gates every register, none wider than four bits.
    function automatic logic lane0(input logic [3:0] be);
        return be[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers; each threshold path passes two flops.

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ttl_meta_q <= 4'h0;
            ttl_sync_q <= 4'h0;
            st_meta_q  <= 4'h0;
            st_sync_q  <= 4'h0;
        end else begin
            ttl_meta_q <= i_pin_in;
            ttl_sync_q <= ttl_meta_q;
            st_meta_q  <= i_pin_schmitt;
            st_sync_q  <= st_meta_q;
        end
    end

    // Choose the threshold per pin and blank analog pins.
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            // R9: threshold per pin
            pin_state[i] = thresh_q[i] ? st_sync_q[i] : ttl_sync_q[i];
        end
        for (int i = 0; i < 3; i++) begin
            // R4: analog reads zero
            if (analog_q[i]) begin
                pin_state[i] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: waitrequest high for one cycle, answer on the second.

    // A request is taken in the cycle waitrequest is low.
    assign wr_hit = i_avs_write && (bus_state_q == FBGP_DONE);
    assign rd_hit = i_avs_read && (bus_state_q == FBGP_DONE);

    // The first cycle of each request gives time to prepare read data.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_state_q <= FBGP_IDLE;
        end else begin
            case (bus_state_q)
                FBGP_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_state_q <= FBGP_DONE;
                    end
                end
                FBGP_DONE: begin
                    bus_state_q <= FBGP_IDLE;
                end
                default: begin
                    bus_state_q <= FBGP_IDLE;
                end
            endcase
        end
    end

    // Waitrequest is low only in the answering cycle.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !((bus_state_q == FBGP_IDLE) && (i_avs_read || i_avs_write));
        end
    end

    // Read data is built while waitrequest is still high.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_state_q == FBGP_IDLE && i_avs_read) begin
            if (i_avs_address == `FBGP_ADDR_PIN_STATE) begin
                // R2: read shows pins
                // R17: upper bits zero
                rdata_q <= {28'h000_0000, pin_state};
            end else if (i_avs_address == `FBGP_ADDR_DIRECTION) begin
                // R6: pin 3 reads one
                rdata_q <= {28'h000_0000, 1'b1, dir_q[2:0]};
            end else if (i_avs_address == `FBGP_ADDR_LATCH) begin
                rdata_q <= {29'h0000_0000, latch_q};
            end else if (i_avs_address == `FBGP_ADDR_ANALOG) begin
                rdata_q <= {29'h0000_0000, analog_q};
            end else if (i_avs_address == `FBGP_ADDR_PULLUP) begin
                rdata_q <= {28'h000_0000, pullup_q};
            end else if (i_avs_address == `FBGP_ADDR_OPEN_DRAIN) begin
                rdata_q <= {29'h0000_0000, odrain_q};
            end else if (i_avs_address == `FBGP_ADDR_SLEW) begin
                rdata_q <= {29'h0000_0000, slew_q};
            end else if (i_avs_address == `FBGP_ADDR_THRESHOLD) begin
                rdata_q <= {28'h000_0000, thresh_q};
            end else if (i_avs_address == `FBGP_ADDR_MCLR_CTRL) begin
                rdata_q <= {31'h0000_0000, mclr_q};
            end else begin
                rdata_q <= `FBGP_UNMAPPED_DATA;
            end
        end
    end

    assign o_avs_readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    // Direction; pin 3 bit is always written one so it can never be made an output.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // R18: direction reset
            dir_q <= `FBGP_RST_DIRECTION;
        end else if (wr_hit && lane0(i_avs_byteenable)
                     && i_avs_address == `FBGP_ADDR_DIRECTION) begin
            // R6: pin 3 fixed input
            dir_q <= {1'b1, i_avs_writedata[2:0]};
        end
    end

    // Output latch, written from either the data or the latch address.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // R18: latch reset
            latch_q <= `FBGP_RST_LATCH;
        end else if (wr_hit && lane0(i_avs_byteenable)) begin
            if (i_avs_address == `FBGP_ADDR_PIN_STATE) begin
                // R2: write goes latch
                // R3: written bits 2..0 replace the sampled pins, so the latch takes them.
                latch_q <= i_avs_writedata[2:0];
            end else if (i_avs_address == `FBGP_ADDR_LATCH) begin
                latch_q <= i_avs_writedata[2:0];
            end
        end
    end

    // Analog selects power up set; digital reads need a clear first.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // R12: analog reset one
            analog_q <= `FBGP_RST_ANALOG;
        end else if (wr_hit && lane0(i_avs_byteenable)
                     && i_avs_address == `FBGP_ADDR_ANALOG) begin
            analog_q <= i_avs_writedata[2:0];
        end
    end

    // Remaining per-pin option registers.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // R18: option resets
            pullup_q <= `FBGP_RST_PULLUP;
            odrain_q <= `FBGP_RST_OPEN_DRAIN;
            slew_q   <= `FBGP_RST_SLEW;
            thresh_q <= `FBGP_RST_THRESHOLD;
            mclr_q   <= `FBGP_RST_MCLR;
        end else if (wr_hit && lane0(i_avs_byteenable)) begin
            if (i_avs_address == `FBGP_ADDR_PULLUP) begin
                pullup_q <= i_avs_writedata[3:0];
            end else if (i_avs_address == `FBGP_ADDR_OPEN_DRAIN) begin
                odrain_q <= i_avs_writedata[2:0];
            end else if (i_avs_address == `FBGP_ADDR_SLEW) begin
                slew_q <= i_avs_writedata[2:0];
            end else if (i_avs_address == `FBGP_ADDR_THRESHOLD) begin
                // A change here may glitch the read path; software orders it.
                thresh_q <= i_avs_writedata[3:0];
            end else if (i_avs_address == `FBGP_ADDR_MCLR_CTRL) begin
                mclr_q <= i_avs_writedata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad drive. Analog select plays no part, so digital output survives it.

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // R1: direction gates driver
            // R15: latch is the source
            // R11: analog ignored here
            // R16: output keeps pin
            // R7: open-drain sinks only
            if (dir_q[i]) begin
                oe_n_d[i]    = 1'b1;
                pin_out_d[i] = 1'b0;
            end else if (odrain_q[i]) begin
                oe_n_d[i]    = latch_q[i];
                pin_out_d[i] = 1'b0;
            end else begin
                oe_n_d[i]    = 1'b0;
                pin_out_d[i] = latch_q[i];
            end
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            // R13: off when output
            pullup_d[i] = pullup_q[i] && dir_q[i];
        end
        // R14: master clear pull-up
        pullup_d[3] = pullup_q[3] || mclr_q;
    end

    // Every pad control leaves from a flop.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin_out     <= 3'h0;
            o_pin_oe_n    <= 3'h7;
            o_slew_limit  <= `FBGP_RST_SLEW;
            o_pullup_on   <= `FBGP_RST_PULLUP;
            o_schmitt_sel <= `FBGP_RST_THRESHOLD;
            o_analog_sel  <= `FBGP_RST_ANALOG;
        end else begin
            o_pin_out     <= pin_out_d;
            o_pin_oe_n    <= oe_n_d;
            // R8: slew per pin
            o_slew_limit  <= slew_q;
            o_pullup_on   <= pullup_d;
            o_schmitt_sel <= thresh_q;
            o_analog_sel  <= analog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_out_cfg(int i);
        !dir_q[i] && !odrain_q[i];
    endsequence

    a_dir_drives: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R1
        s_out_cfg(0) |=> (!o_pin_oe_n[0] && o_pin_out[0] == $past(latch_q[0])))
        else $error("pin 0 not driven from latch");

    a_dir_input: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R1
        dir_q[1] |=> o_pin_oe_n[1])
        else $error("input pin driven");

    a_write_latch: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R2
        (wr_hit && i_avs_byteenable[0] && i_avs_address == `FBGP_ADDR_PIN_STATE)
        |=> latch_q == $past(i_avs_writedata[2:0]))
        else $error("data write missed latch");

    a_analog_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R4
        (bus_state_q == FBGP_IDLE && i_avs_read && i_avs_address == `FBGP_ADDR_PIN_STATE
         && analog_q[2]) |=> !rdata_q[2])
        else $error("analog pin read nonzero");

    a_pin3_input: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R6
        (bus_state_q == FBGP_IDLE && i_avs_read
         && i_avs_address == `FBGP_ADDR_DIRECTION) |=> rdata_q[3])
        else $error("pin 3 direction not one");

    a_odrain_sink: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R7
        (!dir_q[2] && odrain_q[2]) |=> !o_pin_out[2])
        else $error("open drain sourced");

    a_slew_follow: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R8
        ##1 o_slew_limit == $past(slew_q))
        else $error("slew control lagging");

    a_analog_output: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R11
        (analog_q[0] and s_out_cfg(0)) |=> !o_pin_oe_n[0])
        else $error("analog blocked output");

    a_pullup_off: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R13
        !dir_q[1] |=> !o_pullup_on[1])
        else $error("pull-up on output pin");

    a_mclr_pullup: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R14
        mclr_q |=> o_pullup_on[3])
        else $error("pin 3 pull-up not forced");

endmodule // fbgp_port

// ### dv/fbgp_pin_model.sv
`timescale 1ns/10ps
// Outside circuitry on the four pads. The device driver wins, then an outside driver,
// then the weak pull-up. A pad that nobody holds flips every cycle, so no read of a
// released pad can pass by luck.
module fbgp_pin_model (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_pin_out,
    input  wire logic [2:0] i_pin_oe_n,
    input  wire logic [3:0] i_pullup_on,
    input  wire logic [3:0] i_ext_en,
    input  wire logic [3:0] i_ext_val,
    input  wire logic [3:0] i_ext_mid,
    output logic      [3:0] o_ttl,
    output logic      [3:0] o_schmitt
);
    logic       float_q = 1'b0; // Level of an undriven pad.
    logic [3:0] drv_n;          // Device drive enable, pad 3 never driven.
    logic [3:0] drv_v;          // Device drive level.

    assign drv_n = {1'b1, i_pin_oe_n};
    assign drv_v = {1'b0, i_pin_out};

    // The floating level changes each cycle.
    always_ff @(posedge i_clk) begin
        float_q <= ~float_q;
    end

    // Resolve every pad; a mid level passes the TTL threshold only.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (drv_n[i] === 1'b0) begin
                o_ttl[i] = drv_v[i];
                o_schmitt[i] = drv_v[i];
            end else if (i_ext_en[i]) begin
                o_ttl[i] = i_ext_mid[i] | i_ext_val[i];
                o_schmitt[i] = ~i_ext_mid[i] & i_ext_val[i];
            end else begin
                o_ttl[i] = i_pullup_on[i] | float_q;
                o_schmitt[i] = i_pullup_on[i] | float_q;
            end
        end
    end
endmodule // fbgp_pin_model

// ### dv/fbgp_port_tb_top.sv
`timescale 1ns/10ps
`include "fbgp_defines.svh"

module fbgp_port_tb_top;
    import fbgp_pkg::*;

    logic          clk = 1'b0;        // System clock.
    logic          arst_n = 1'b0;     // Reset, active low.
    logic [7:0]    adr = 8'h00;       // Bus address.
    logic          rd = 1'b0;         // Read request.
    logic          wr = 1'b0;         // Write request.
    logic [31:0]   wdat = 32'h0;      // Write data.
    logic [3:0]    be = 4'hF;         // Byte enables.
    logic [31:0]   rdat;              // Read data.
    logic          wait_q;            // Wait request.
    fbgp_pins_type ttl, st, pu, ssel; // Pad inputs and controls.
    fbgp_out_type  pout, oe_n, slew, ana;
    logic [3:0]    ext_en = 4'h0;     // Outside driver enable.
    logic [3:0]    ext_val = 4'h0;    // Outside driver level.
    logic [3:0]    ext_mid = 4'h0;    // Pad held between thresholds.
    logic [31:0]   got;               // Last word read.
    int            fails = 0;
    int            n_tests = 0;
    int            cycles = 0;

    fbgp_port uut (.i_clk(clk), .i_arst_n(arst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_q),
        .i_pin_in(ttl), .i_pin_schmitt(st), .o_pin_out(pout), .o_pin_oe_n(oe_n),
        .o_slew_limit(slew), .o_pullup_on(pu), .o_schmitt_sel(ssel), .o_analog_sel(ana));

    fbgp_pin_model u_pins (.i_clk(clk), .i_pin_out(pout), .i_pin_oe_n(oe_n),
        .i_pullup_on(pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .i_ext_mid(ext_mid),
        .o_ttl(ttl), .o_schmitt(st));

    initial begin
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Case-equality compare, so an unknown never matches.
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One transfer; the request holds until wait request is sampled low.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] b);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wdat <= d;
        be <= b;
        @(posedge clk);
        while (wait_q !== 1'b0) begin
            @(posedge clk);
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        // One idle edge keeps two requests from landing in one time step.
        @(posedge clk);
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 4'hF);
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0, 4'hF);
        check(got, e);
    endtask

    // Pads update after the write and then pass two sync flops.
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(32'(oe_n), 32'h7);
        check(32'(pu), 32'hF);
        check(32'(slew), 32'h7);
        check(32'(ssel), 32'hF);
        check(32'(ana), 32'h7);
        get(`FBGP_ADDR_DIRECTION, 32'hF);
        get(`FBGP_ADDR_LATCH, 32'h7);
        get(`FBGP_ADDR_ANALOG, 32'h7);
        get(`FBGP_ADDR_PULLUP, 32'hF);
        get(`FBGP_ADDR_OPEN_DRAIN, 32'h0);
        get(`FBGP_ADDR_SLEW, 32'h7);
        get(`FBGP_ADDR_THRESHOLD, 32'hF);
        get(`FBGP_ADDR_MCLR_CTRL, 32'h0);
        get(`FBGP_ADDR_PIN_STATE, 32'h8);
        $display("t_reset done");
    endtask

    task automatic t_drive;
        put(`FBGP_ADDR_ANALOG, 32'h0);
        put(`FBGP_ADDR_DIRECTION, 32'h0);
        put(`FBGP_ADDR_LATCH, 32'h5);
        settle();
        get(`FBGP_ADDR_DIRECTION, 32'h8);
        check(32'(oe_n), 32'h0);
        check(32'(pout), 32'h5);
        check(32'(pu), 32'h8);
        get(`FBGP_ADDR_PIN_STATE, 32'hD);
        $display("t_drive done");
    endtask

    task automatic t_port_write;
        put(`FBGP_ADDR_PIN_STATE, 32'hA);
        get(`FBGP_ADDR_LATCH, 32'h2);
        // Byte lane zero off: the write must be dropped.
        xfer(`FBGP_ADDR_LATCH, 1'b1, 32'h7, 4'hE);
        get(`FBGP_ADDR_LATCH, 32'h2);
        settle();
        check(32'(pout), 32'h2);
        get(`FBGP_ADDR_PIN_STATE, 32'hA);
        put(8'h24, 32'hF);
        get(8'h24, 32'h0);
        $display("t_port_write done");
    endtask

    task automatic t_open_drain;
        put(`FBGP_ADDR_OPEN_DRAIN, 32'h5);
        put(`FBGP_ADDR_LATCH, 32'h7);
        settle();
        check(32'(oe_n), 32'h5);
        check(32'(pout[1]), 32'h1);
        put(`FBGP_ADDR_LATCH, 32'h0);
        settle();
        check(32'(oe_n), 32'h0);
        check(32'(pout), 32'h0);
        put(`FBGP_ADDR_OPEN_DRAIN, 32'h0);
        $display("t_open_drain done");
    endtask

    task automatic t_analog_out;
        put(`FBGP_ADDR_LATCH, 32'h5);
        put(`FBGP_ADDR_ANALOG, 32'h7);
        settle();
        check(32'(ana), 32'h7);
        check(32'(pout), 32'h5);
        check(32'(oe_n), 32'h0);
        get(`FBGP_ADDR_PIN_STATE, 32'h8);
        put(`FBGP_ADDR_ANALOG, 32'h0);
        $display("t_analog_out done");
    endtask

    task automatic t_threshold;
        put(`FBGP_ADDR_SLEW, 32'h2);
        // every pad stays an input while the outside driver holds it.
        put(`FBGP_ADDR_DIRECTION, 32'hF);
        ext_en <= 4'hF;
        ext_mid <= 4'hF;
        settle();
        check(32'(slew), 32'h2);
        // thresholds change only while nothing else uses the pads.
        for (int t = 0; t < 16; t += 5) begin
            put(`FBGP_ADDR_THRESHOLD, 32'(t));
            settle();
            check(32'(ssel), 32'(t));
            get(`FBGP_ADDR_PIN_STATE, 32'(~t & 15));
        end
        ext_en <= 4'h0;
        $display("t_threshold done");
    endtask

    task automatic t_pullup;
        put(`FBGP_ADDR_PULLUP, 32'h0);
        settle();
        check(32'(pu), 32'h0);
        put(`FBGP_ADDR_MCLR_CTRL, 32'h1);
        settle();
        check(32'(pu), 32'h8);
        get(`FBGP_ADDR_PULLUP, 32'h0);
        put(`FBGP_ADDR_DIRECTION, 32'hE);
        put(`FBGP_ADDR_PULLUP, 32'h3);
        settle();
        check(32'(pu), 32'hA);
        $display("t_pullup done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the fewer than two hundred cycles the tests need.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_drive();
        t_port_write();
        t_open_drain();
        t_analog_out();
        t_threshold();
        t_pullup();
        results();
    end
endmodule // fbgp_port_tb_top
